// File: verilog/xform_mode_pkg.sv
// package: offsets, field layouts and encodings of the transform mode vector shadow
package xform_mode_pkg;

  // ********************************************************************
  // generations
  // ********************************************************************
  typedef enum logic [1:0] {GEN_FIRST, GEN_SECOND, GEN_THIRD} generation_t;

  // ********************************************************************
  // shadow register byte offsets
  // ********************************************************************
  localparam logic [23:0] OFF_GEN1_WORD_B  = 24'h40_0f40;
  localparam logic [23:0] OFF_GEN1_WORD_A  = 24'h40_0f44;
  localparam logic [23:0] OFF_GEN2_WORD_B  = 24'h40_0fb4;
  localparam logic [23:0] OFF_GEN2_WORD_A  = 24'h40_0fb8;
  localparam logic [23:0] OFF_GEN2_TEX1    = 24'h40_0fbc;
  localparam logic [23:0] OFF_GEN2_TEX0    = 24'h40_0fc0;
  localparam logic [23:0] OFF_GEN3_DUMMY   = 24'h40_0fb4;
  localparam logic [23:0] OFF_GEN3_WORD_C  = 24'h40_0fb8;
  localparam logic [23:0] OFF_GEN3_WORD_B  = 24'h40_0fbc;
  localparam logic [23:0] OFF_GEN3_WORD_A  = 24'h40_0fc0;
  localparam logic [23:0] OFF_GEN3_TEX3    = 24'h40_0fc4;
  localparam logic [23:0] OFF_GEN3_TEX2    = 24'h40_0fc8;
  localparam logic [23:0] OFF_GEN3_TEX1    = 24'h40_0fcc;
  localparam logic [23:0] OFF_GEN3_TEX0    = 24'h40_0fd0;

  // ********************************************************************
  // reset values and writable masks
  // ********************************************************************
  localparam logic [31:0] RESET_WORD       = 32'h0000_0000;
  localparam logic [31:0] MASK_GEN1_WORD_A = 32'hffff_ffff;
  localparam logic [31:0] MASK_GEN1_WORD_B = 32'h3bff_ffff;
  localparam logic [31:0] MASK_WORD_A      = 32'hffff_ffff;
  localparam logic [31:0] MASK_GEN2_WORD_B = 32'hffff_ffff;
  localparam logic [31:0] MASK_GEN3_WORD_B = 32'hfeff_ffff;
  localparam logic [31:0] MASK_WORD_C      = 32'h0000_003f;
  localparam logic [31:0] MASK_TEX_WORD    = 32'hfff7_fff7;

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int G1_TEX1_BASE   = 14;
  localparam int G1_FOG_LSB     = 16;
  localparam int G1_BYPASS_BIT  = 28;
  localparam int G1_VP_OFS_BIT  = 29;
  localparam int LIGHT_W        = 2;
  localparam int NUM_LIGHTS     = 8;
  localparam int PROG_START_LSB = 8;
  localparam int VP_SKIP_BIT    = 16;
  localparam int ARITH_BIT      = 17;
  localparam int CTX_VIS_BIT    = 18;
  localparam int FOG2_LSB       = 22;
  localparam int CTX_WRITE_BIT  = 29;
  localparam int OP_MODE_LSB    = 30;
  localparam int TEXW_ODD_BASE  = 16;
  localparam int CLIP_W         = 6;

  // ********************************************************************
  // encodings
  // ********************************************************************
  typedef enum logic [1:0] {LIGHT_OFF, LIGHT_INFINITE, LIGHT_LOCAL, LIGHT_SPOT} light_mode_t;
  typedef enum logic [1:0] {OP_FIXED, OP_BYPASS_OR_V3, OP_PROG_ONE, OP_PROG_TWO} op_mode_t;
  typedef enum logic [2:0] {
    TG_PASS, TG_EYE_LINEAR, TG_OBJECT_LINEAR, TG_SPHERE, TG_NORMAL, TG_REFLECT, TG_EMBOSS
  } texgen_t;

  // mode command to the transform engine: two vectors of 128 bits
  typedef struct packed {
    logic [127:0] vector1;
    logic [127:0] vector0;
  } mode_command_t;

  // decoded controls taken from word b, program start from word a
  typedef struct packed {
    logic       viewportSkip;
    logic       arithmeticSemantics;
    logic       contextVisibility;
    logic       contextWritePermit;
    logic       fixedFunctionOff;
    logic [1:0] operatingMode;
    logic [7:0] programStart;
  } engine_controls_t;

endpackage

// File: verilog/vertex_transform_mode_vector.sv
// shadow copy of the vertex transform mode vector with command push to the engine
`timescale 1ns/1ps

module vertex_transform_mode_vector
  import xform_mode_pkg::*;
#(
  parameter generation_t GENERATION = GEN_THIRD
) (
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          regWrite,
  input  wire logic          regRead,
  input  wire logic [23:0]   regAddr,
  input  wire logic [31:0]   regWriteData,
  output      logic [31:0]   regReadData,
  output      logic          regReadValid,
  input  wire logic          methodValid,
  input  wire logic [2:0]    methodWord,
  input  wire logic [31:0]   methodData,
  output      logic          modeCommandValid,
  output      mode_command_t modeCommand,
  input  wire logic          modeCommandReady,
  output      engine_controls_t engineControls,
  output      logic [1:0]    fogSource,
  output      logic          bypassActive,
  output      logic          viewportOffsetCenter,
  output      logic [5:0]    userClipEnables
);

  // ********************************************************************
  // elaboration check
  // ********************************************************************
  if (GENERATION != GEN_FIRST && GENERATION != GEN_SECOND && GENERATION != GEN_THIRD) begin : g_bad
    $error("unsupported generation");
  end

  // ********************************************************************
  // word slots: 0 a, 1 b, 2 c, 3..6 texture 0..3, 7 none
  // ********************************************************************
  localparam logic [2:0] SLOT_A    = 3'h0;
  localparam logic [2:0] SLOT_B    = 3'h1;
  localparam logic [2:0] SLOT_C    = 3'h2;
  localparam logic [2:0] SLOT_T0   = 3'h3;
  localparam logic [2:0] SLOT_NONE = 3'h7;

  logic [31:0] shadow_reg [0:6];
  logic        dirty_reg;
  logic        pushPending_reg;

  // map byte address to slot for the built generation
  function automatic logic [2:0] slot_of(input logic [23:0] addr);
    logic [2:0] s;
    s = SLOT_NONE;
    unique case (GENERATION)
      GEN_FIRST: begin
        if (addr == OFF_GEN1_WORD_B) s = SLOT_B;
        if (addr == OFF_GEN1_WORD_A) s = SLOT_A;
      end
      // b, a, texture 1, texture 0
      GEN_SECOND: begin
        if (addr == OFF_GEN2_WORD_B) s = SLOT_B;
        if (addr == OFF_GEN2_WORD_A) s = SLOT_A;
        if (addr == OFF_GEN2_TEX1)   s = 3'h4;
        if (addr == OFF_GEN2_TEX0)   s = SLOT_T0;
      end
      // dummy word maps to no slot and reads zero
      default: begin
        if (addr == OFF_GEN3_WORD_C) s = SLOT_C;
        if (addr == OFF_GEN3_WORD_B) s = SLOT_B;
        if (addr == OFF_GEN3_WORD_A) s = SLOT_A;
        if (addr == OFF_GEN3_TEX3)   s = 3'h6;
        if (addr == OFF_GEN3_TEX2)   s = 3'h5;
        if (addr == OFF_GEN3_TEX1)   s = 3'h4;
        if (addr == OFF_GEN3_TEX0)   s = SLOT_T0;
      end
    endcase
    return s;
  endfunction

  // writable bits per slot; everything else stays zero
  function automatic logic [31:0] mask_of(input logic [2:0] slot);
    logic [31:0] m;
    m = 32'h0000_0000;
    unique case (GENERATION)
      GEN_FIRST: begin
        // only words a and b exist
        if (slot == SLOT_A) m = MASK_GEN1_WORD_A;
        if (slot == SLOT_B) m = MASK_GEN1_WORD_B;
      end
      GEN_SECOND: begin
        if (slot == SLOT_A) m = MASK_WORD_A;
        if (slot == SLOT_B) m = MASK_GEN2_WORD_B;
        // texture words keep every gen select bit, only gaps read zero
        if (slot == SLOT_T0 || slot == 3'h4) m = MASK_TEX_WORD;
      end
      default: begin
        // word c carries six clip enables only
        if (slot == SLOT_A) m = MASK_WORD_A;
        if (slot == SLOT_B) m = MASK_GEN3_WORD_B;
        if (slot == SLOT_C) m = MASK_WORD_C;
        if (slot >= SLOT_T0 && slot != SLOT_NONE) m = MASK_TEX_WORD;
      end
    endcase
    return m;
  endfunction

  // ********************************************************************
  // shadow update from register writes and mode methods
  // ********************************************************************
  logic [2:0]  wrSlot;
  logic [31:0] wrData;
  logic        wrHit;

  always_comb begin
    wrSlot = SLOT_NONE;
    wrData = 32'h0000_0000;
    if (regWrite) begin
      wrSlot = slot_of(regAddr);
      wrData = regWriteData;
    end else if (methodValid) begin
      wrSlot = methodWord;
      wrData = methodData;
    end
    wrHit = (wrSlot != SLOT_NONE) && (mask_of(wrSlot) != 32'h0000_0000);
  end

  // the shadow is the saved context; reset clears it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 7; i++) begin
        shadow_reg[i] <= RESET_WORD;
      end
    end else if (wrHit) begin
      // methods and register writes both land in the shadow; a register write wins over a method in the same cycle
      shadow_reg[wrSlot] <= wrData & mask_of(wrSlot);
    end
  end

  // ********************************************************************
  // command push
  // ********************************************************************
  logic changeSeen;

  always_comb begin
    changeSeen = 1'b0;
    if (wrHit) begin
      if (GENERATION == GEN_FIRST) begin
        // only a low-word write pushes in the first generation
        changeSeen = (wrSlot == SLOT_A);
      end else begin
        // any change in a later generation
        changeSeen = ((wrData & mask_of(wrSlot)) != shadow_reg[wrSlot]);
      end
    end
  end

  // a change arriving while a push waits loads a fresh vector at the edge that takes the pending one
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dirty_reg <= 1'b0;
    end else if (changeSeen) begin
      dirty_reg <= 1'b1;
    end else if (!pushPending_reg || modeCommandReady) begin
      dirty_reg <= 1'b0;
    end
  end

  mode_command_t commandNext;

  always_comb begin
    commandNext = '0;
    unique case (GENERATION)
      GEN_FIRST: commandNext.vector0 = {64'h0, shadow_reg[1], shadow_reg[0]};
      // texture 0 lowest, word b highest
      GEN_SECOND: commandNext.vector0 = {shadow_reg[1], shadow_reg[0], shadow_reg[4], shadow_reg[3]};
      // vector 0 a, b, c; vector 1 four texture words
      default: begin
        commandNext.vector0 = {32'h0, shadow_reg[2], shadow_reg[1], shadow_reg[0]};
        commandNext.vector1 = {shadow_reg[6], shadow_reg[5], shadow_reg[4], shadow_reg[3]};
      end
    endcase
  end

  // offer the current vector until the engine takes it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pushPending_reg  <= 1'b0;
      modeCommandValid <= 1'b0;
      modeCommand      <= '0;
    end else if (dirty_reg && (!modeCommandValid || modeCommandReady)) begin
      pushPending_reg  <= 1'b1;
      modeCommandValid <= 1'b1;
      modeCommand      <= commandNext;
    end else if (modeCommandValid && modeCommandReady) begin
      pushPending_reg  <= 1'b0;
      modeCommandValid <= 1'b0;
    end
  end

  // ********************************************************************
  // register reads
  // ********************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regReadData  <= 32'h0000_0000;
      regReadValid <= 1'b0;
    end else begin
      regReadValid <= regRead;
      if (regRead && slot_of(regAddr) != SLOT_NONE) begin
        regReadData <= shadow_reg[slot_of(regAddr)];
      end else begin
        // dummy and unmapped words read zero
        regReadData <= 32'h0000_0000;
      end
    end
  end

  // ********************************************************************
  // decoded controls
  // ********************************************************************
  logic [31:0] wordA;
  logic [31:0] wordB;

  assign wordA = shadow_reg[0];
  assign wordB = shadow_reg[1];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      engineControls       <= '0;
      fogSource            <= 2'b00;
      bypassActive         <= 1'b0;
      viewportOffsetCenter <= 1'b0;
      userClipEnables      <= 6'h00;
    end else if (GENERATION == GEN_FIRST) begin
      engineControls       <= '0;
      fogSource            <= wordB[G1_FOG_LSB +: 2];
      bypassActive         <= wordB[G1_BYPASS_BIT];
      viewportOffsetCenter <= wordB[G1_BYPASS_BIT] & wordB[G1_VP_OFS_BIT];
      userClipEnables      <= 6'h00;
    end else begin
      engineControls.viewportSkip        <= wordB[VP_SKIP_BIT];
      engineControls.arithmeticSemantics <= wordB[ARITH_BIT];
      engineControls.contextVisibility   <= wordB[CTX_VIS_BIT];
      engineControls.contextWritePermit  <= wordB[CTX_WRITE_BIT];
      engineControls.operatingMode       <= wordB[OP_MODE_LSB +: 2];
      engineControls.fixedFunctionOff    <= wordB[OP_MODE_LSB +: 2] == OP_PROG_ONE
                                         || wordB[OP_MODE_LSB +: 2] == OP_PROG_TWO
                                         || (GENERATION == GEN_THIRD
                                             && wordB[OP_MODE_LSB +: 2] == OP_BYPASS_OR_V3);
      engineControls.programStart        <= wordA[PROG_START_LSB +: 8];
      fogSource                          <= wordB[FOG2_LSB +: 2];
      bypassActive                       <= GENERATION == GEN_SECOND
                                         && wordB[OP_MODE_LSB +: 2] == OP_BYPASS_OR_V3;
      viewportOffsetCenter               <= 1'b0;
      userClipEnables                    <= GENERATION == GEN_THIRD ? shadow_reg[2][CLIP_W-1:0] : 6'h00;
    end
  end

endmodule

// File: dv/vertex_transform_mode_vector_sva.sv
// concurrent checks on the ports of the transform mode vector shadow
`timescale 1ns/1ps

module vertex_transform_mode_vector_sva
  import xform_mode_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             reset,
  input wire logic             regWrite,
  input wire logic             regRead,
  input wire logic [23:0]      regAddr,
  input wire logic [31:0]      regWriteData,
  input wire logic [31:0]      regReadData,
  input wire logic             regReadValid,
  input wire logic             methodValid,
  input wire logic [2:0]       methodWord,
  input wire logic [31:0]      methodData,
  input wire logic             modeCommandValid,
  input wire mode_command_t    modeCommand,
  input wire logic             modeCommandReady,
  input wire engine_controls_t engineControls,
  input wire logic [1:0]       fogSource,
  input wire logic             bypassActive,
  input wire logic             viewportOffsetCenter,
  input wire logic [5:0]       userClipEnables
);
  // ****************************************************************
  // any update since the offered command was loaded; a merged change
  // may reload a fresh snapshot right at the acceptance edge
  // ****************************************************************
  logic changeSinceLoad;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      changeSinceLoad <= 1'b0;
    end else if (!modeCommandValid || modeCommandReady) begin
      changeSinceLoad <= regWrite || methodValid;
    end else begin
      changeSinceLoad <= changeSinceLoad || regWrite || methodValid;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_READ_ANSWER: assert property (regRead |=> regReadValid)
    else $error("read strobe got no valid answer");
  AST_READ_PULSE: assert property (!regRead |=> !regReadValid)
    else $error("read valid without a read");
  AST_DUMMY_ZERO: assert property (regRead && (regAddr == OFF_GEN3_DUMMY || regAddr > OFF_GEN3_TEX0)
    |=> regReadData == 32'h0000_0000) else $error("dummy or unmapped word read nonzero");
  AST_CMD_HOLD: assert property (modeCommandValid && !modeCommandReady
    |=> modeCommandValid && $stable(modeCommand)) else $error("pending command dropped or changed");
  AST_CMD_TAKEN: assert property (modeCommandValid && modeCommandReady && !changeSinceLoad
    |=> !modeCommandValid) else $error("command still valid after acceptance");
  AST_CMD_LAYOUT: assert property (modeCommandValid |-> modeCommand.vector0[127:70] == 58'h0)
    else $error("unused command bits set");
  AST_PROG_OFF: assert property (engineControls.operatingMode[1] |-> engineControls.fixedFunctionOff)
    else $error("program mode left fixed function on");
  AST_CLIP_MAP: assert property (regWrite && regAddr == OFF_GEN3_WORD_C
    |-> ##2 userClipEnables == $past(regWriteData[5:0], 2)) else $error("clip enables do not follow word c");
  AST_FOG_MAP: assert property (regWrite && regAddr == OFF_GEN3_WORD_B
    |-> ##2 fogSource == $past(regWriteData[23:22], 2)) else $error("fog source does not follow word b");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) reset
    |=> !modeCommandValid && !regReadValid && userClipEnables == 6'h00) else $error("outputs not cleared");
endmodule

bind vertex_transform_mode_vector vertex_transform_mode_vector_sva checker_inst (
  .sys_clk(sys_clk), .reset(reset), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
  .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
  .methodValid(methodValid), .methodWord(methodWord), .methodData(methodData),
  .modeCommandValid(modeCommandValid), .modeCommand(modeCommand), .modeCommandReady(modeCommandReady),
  .engineControls(engineControls), .fogSource(fogSource), .bypassActive(bypassActive),
  .viewportOffsetCenter(viewportOffsetCenter), .userClipEnables(userClipEnables));

// File: dv/transform_engine_model.sv
// behavioural transform engine taking mode commands
`timescale 1ns/1ps

module transform_engine_model
  import xform_mode_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          stall,
  input  wire logic          modeCommandValid,
  input  wire mode_command_t modeCommand,
  output      logic          modeCommandReady,
  output      mode_command_t lastCommand,
  output      logic [15:0]   acceptCount
);
  logic [1:0] tick;

  // stalling engine accepts only one cycle in four
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick             <= 2'h0;
      modeCommandReady <= 1'b0;
    end else begin
      tick             <= tick + 2'h1;
      modeCommandReady <= !stall || tick == 2'h3;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acceptCount <= 16'h0000;
    end else if (modeCommandValid && modeCommandReady) begin
      lastCommand <= modeCommand;
      acceptCount <= acceptCount + 16'h0001;
    end
  end
endmodule

// File: dv/vertex_transform_mode_vector_test.sv
// self-checking bench for the transform mode vector shadow
`timescale 1ns/1ps

module vertex_transform_mode_vector_test
  import xform_mode_pkg::*;
;
  logic             sys_clk, reset, regWrite, regRead, methodValid, stall;
  logic [23:0]      regAddr;
  logic [31:0]      regWriteData, methodData, regReadData, d;
  logic [2:0]       methodWord;
  logic             regReadValid, modeCommandValid, modeCommandReady, bypassActive, viewportOffsetCenter;
  mode_command_t    modeCommand, lastCommand;
  engine_controls_t engineControls;
  logic [1:0]       fogSource;
  logic [5:0]       userClipEnables;
  logic [15:0]      acceptCount, expCount;
  logic [31:0]      shadow [8];
  int               errorCnt, nCompared, seed, k, n;
  // dummy, c, b, a, texture 3..0 in address order
  logic [31:0] maskTab [8] = '{32'h0000_0000, MASK_WORD_C, MASK_GEN3_WORD_B, MASK_WORD_A,
                               MASK_TEX_WORD, MASK_TEX_WORD, MASK_TEX_WORD, MASK_TEX_WORD};

  vertex_transform_mode_vector dut (.sys_clk(sys_clk), .reset(reset), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
    .methodValid(methodValid), .methodWord(methodWord), .methodData(methodData),
    .modeCommandValid(modeCommandValid), .modeCommand(modeCommand), .modeCommandReady(modeCommandReady),
    .engineControls(engineControls), .fogSource(fogSource), .bypassActive(bypassActive),
    .viewportOffsetCenter(viewportOffsetCenter), .userClipEnables(userClipEnables));

  transform_engine_model engine (.sys_clk(sys_clk), .reset(reset), .stall(stall),
    .modeCommandValid(modeCommandValid), .modeCommand(modeCommand), .modeCommandReady(modeCommandReady),
    .lastCommand(lastCommand), .acceptCount(acceptCount));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // checking and bus tasks
  // ****************************************************************
  task automatic complete_run;
    if (errorCnt == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    nCompared++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [255:0] expCmd();
    return {shadow[4], shadow[5], shadow[6], shadow[7], 32'h0000_0000, shadow[1], shadow[2], shadow[3]};
  endfunction

  // lights above the first disabled one stay disabled
  function automatic logic [31:0] lights(input logic [31:0] v);
    for (int j = 0; j < 8; j++) begin
      if (j >= v[18:16]) v[2*j +: 2] = 2'b00;
      else if (v[2*j +: 2] == 2'b00) v[2*j +: 2] = 2'b01;
    end
    return v;
  endfunction

  // index 8 is the first word past the map
  task automatic wr(input int i, input logic [31:0] v);
    @(negedge sys_clk);
    regWrite = 1'b1;
    regAddr = OFF_GEN3_DUMMY + 24'(4 * i);
    regWriteData = v;
    @(negedge sys_clk);
    regWrite = 1'b0;
    if (i < 8 && (v & maskTab[i]) != shadow[i]) expCount++;
    if (i < 8) shadow[i] = v & maskTab[i];
  endtask

  task automatic rd(input int i);
    @(negedge sys_clk);
    regRead = 1'b1;
    regAddr = OFF_GEN3_DUMMY + 24'(4 * i);
    @(negedge sys_clk);
    regRead = 1'b0;
    chk(regReadValid, 1'b1);
    chk(regReadData, i < 8 ? shadow[i] : 32'h0000_0000);
  endtask

  // wait out the command push, then compare the engine and every output except fixedFunctionOff and the read port
  task automatic settle;
    repeat (4) @(negedge sys_clk);
    for (n = 0; n < 100 && modeCommandValid !== 1'b0; n++) @(negedge sys_clk);
    chk(modeCommandValid, 1'b0);
    if (n == 100) complete_run;
    chk(acceptCount, expCount);
    if (expCount != 0) chk(lastCommand, expCmd());
    chk(fogSource, shadow[2][23:22]);
    chk(userClipEnables, shadow[1][5:0]);
    chk(engineControls.programStart, shadow[3][15:8]);
    chk(engineControls.viewportSkip, shadow[2][16]);
    chk(engineControls.arithmeticSemantics, shadow[2][17]);
    chk(engineControls.contextVisibility, shadow[2][18]);
    chk(engineControls.contextWritePermit, shadow[2][29]);
    chk(engineControls.operatingMode, shadow[2][31:30]);
    chk({bypassActive, viewportOffsetCenter}, 2'b00);
  endtask

  task automatic restart;
    @(negedge sys_clk);
    reset = 1'b1;
    expCount = 16'h0000;
    for (int j = 0; j < 8; j++) shadow[j] = RESET_WORD;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = 18;
    errorCnt = 0;
    nCompared = 0;
    {regWrite, regRead, methodValid, stall} = 4'h0;
    regAddr = 24'h00_0000;
    regWriteData = 32'h0000_0000;
    methodWord = 3'h7;
    methodData = 32'h0000_0000;
    restart();
    for (k = 0; k < 9; k++) rd(k);
    // every word randomly, fast then stalling engine, unmapped word included
    for (k = 0; k < 18; k++) begin
      stall = (k >= 9);
      d = $random(seed);
      if (k % 9 == 2) d = lights(d);
      wr(k % 9, d);
      settle();
      rd(k % 9);
    end
    // same value again pushes nothing
    wr(3, shadow[3]);
    settle();
    // every operating mode
    for (k = 0; k < 4; k++) begin
      wr(2, {k[1:0], 30'h0000_0000});
      settle();
      chk(engineControls.fixedFunctionOff, k != 0);
    end
    // method slots, then a method colliding with a write
    for (k = 0; k < 7; k++) begin
      d = $random(seed);
      @(negedge sys_clk);
      {methodValid, methodWord, methodData} = {1'b1, k[2:0], d};
      @(negedge sys_clk);
      methodValid = 1'b0;
      n = (k < 3) ? 3 - k : 10 - k;
      if ((d & maskTab[n]) != shadow[n]) expCount++;
      shadow[n] = d & maskTab[n];
      settle();
    end
    // the method must stand at the very edge that takes the write
    fork
      wr(3, 32'h1234_5678);
      begin
        @(negedge sys_clk);
        {methodValid, methodWord, methodData} = {1'b1, 3'h2, 32'hffff_ffff};
        @(negedge sys_clk);
        methodValid = 1'b0;
      end
    join
    settle();
    rd(1);
    // second reset clears the shadow
    restart();
    for (k = 1; k < 4; k++) rd(k);
    settle();
    complete_run();
  end
endmodule
